// *** verif/acp_atm_master.sv ***
// Behavioural model of the external ATM master that drives the link clocks.
// Assumes the bench calls its tasks one at a time; clocks stand still between.
`timescale 1ns/1ns
`default_nettype none
module acp_atm_master (
  // Receive link driven towards the port
  output logic rx_link_clock,
  output logic rx_soc,
  output logic [7:0] rx_data,
  // Transmit link clock
  output logic tx_link_clock
);
  // Link lines idle low
  initial begin
    rx_link_clock = 1'b0;
    rx_soc = 1'b0;
    rx_data = 8'h00;
    tx_link_clock = 1'b0;
  end
  // One receive byte, held well around the rising edge, then scrambled
  task automatic rx_byte(input logic s, input logic [7:0] b);
    rx_soc = s;
    rx_data = b;
    #200;
    rx_link_clock = 1'b1;
    #200;
    rx_link_clock = 1'b0;
    rx_soc = ~s;
    rx_data = ~b;
  endtask : rx_byte
  // One transmit clock period; reset only comes when traffic is idle
  task automatic tx_edge();
    tx_link_clock = 1'b1;
    #200;
    tx_link_clock = 1'b0;
    #200;
  endtask : tx_edge
endmodule : acp_atm_master
`default_nettype wire

// *** verif/acp_port_tb_top.sv ***
// Self-checking bench of the cell port error block, random data, fixed seed.
// Assumes the design files and the ATM master model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "acp_consts.svh"
module acp_port_tb_top;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, shared_cpu_irq, e;
  logic tx_soc, tx_bv, rclk, rsoc, xclk;
  logic [7:0] paddr, tx_data, rdat;
  logic [31:0] pwdata, prdata, r, w1, w2;
  logic [7:0] b [4];
  int num_errors, compares;
  // Design and far-end model
  acp_port acp_port_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_link_clock(rclk), .rx_soc(rsoc), .rx_data(rdat),
    .tx_link_clock(xclk), .tx_soc(tx_soc), .tx_data(tx_data), .tx_byte_valid(tx_bv),
    .shared_cpu_irq(shared_cpu_irq));
  acp_atm_master acp_atm_master_i (.rx_link_clock(rclk), .rx_soc(rsoc), .rx_data(rdat),
    .tx_link_clock(xclk));
  // Peripheral clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; waits for pready with no assumed latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // pready is read at the rising edge, before that edge updates the design
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 4000);
    if (n >= 4000) num_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rdc
  task automatic irqc(input logic x);
    @(negedge clk);
    chk({31'h0, shared_cpu_irq}, {31'h0, x});
  endtask : irqc
  // Four random receive bytes, first one optionally starting a cell
  task automatic rxw(input logic s);
    for (int i = 0; i < 4; i++) begin
      b[i] = 8'($urandom);
      acp_atm_master_i.rx_byte(s && i == 0, b[i]);
    end
    repeat (8) @(posedge clk);
  endtask : rxw
  function automatic logic [31:0] pack(input logic be);
    pack = be ? {b[0], b[1], b[2], b[3]} : {b[3], b[2], b[1], b[0]};
  endfunction : pack
  // Four transmit bytes of a word, low byte first
  task automatic txw(input logic [31:0] w, input logic s);
    for (int i = 0; i < 4; i++) begin
      acp_atm_master_i.tx_edge();
      chk({22'h0, tx_soc, tx_bv, tx_data}, {22'h0, s && i == 0, 1'b1, w[8*i+:8]});
    end
  endtask : txw
  task automatic test_done();
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  // Watchdog
  initial begin
    #400000;
    num_errors++;
    test_done();
  end
  // Main sequence
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    void'($urandom(32'hA4E34BC6));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(`ACP_OFF_PEND, 32'h0);
    rdc(`ACP_OFF_CTRL, 32'h0);
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, e}, 32'h1);
    w1 = $urandom;
    apb(1'b1, `ACP_OFF_ENAB, w1);
    rdc(`ACP_OFF_ENAB, w1 & `ACP_ERR_MASK);
    // Clock present with both directions off
    acp_atm_master_i.rx_byte(1'b0, 8'h00);
    acp_atm_master_i.tx_edge();
    repeat (8) @(posedge clk);
    rdc(`ACP_OFF_PEND, 32'h0004_0004);
    apb(1'b1, `ACP_OFF_ENAB, 32'h0004_0000);
    irqc(1'b1);
    apb(1'b1, `ACP_OFF_PEND, 32'h0004_0000);
    rdc(`ACP_OFF_PEND, 32'h0000_0004);
    irqc(1'b0);
    apb(1'b1, `ACP_OFF_PEND, 32'hFFFF_FFFF);
    // Runt cell then packing, then swapped order
    apb(1'b1, `ACP_OFF_CTRL, 32'h1);
    acp_atm_master_i.rx_byte(1'b1, 8'(~$urandom));
    acp_atm_master_i.rx_byte(1'b0, 8'($urandom));
    rxw(1'b1);
    rdc(`ACP_OFF_RXQ, pack(1'b0));
    apb(1'b1, `ACP_OFF_CTRL, 32'h5);
    rxw(1'b1);
    rdc(`ACP_OFF_RXQ, pack(1'b1));
    // Read of an empty receive queue stalls
    apb(1'b1, `ACP_OFF_CTRL, 32'h1);
    apb(1'b1, `ACP_OFF_ENAB, 32'h1);
    fork
      apb(1'b0, `ACP_OFF_RXQ, 32'h0);
      begin
        repeat (12) @(negedge clk);
        chk({31'h0, shared_cpu_irq}, 32'h1);
        rxw(1'b0);
      end
    join
    chk(r, pack(1'b0));
    irqc(1'b0);
    // Write to a full transmit queue stalls
    apb(1'b1, `ACP_OFF_ENAB, 32'h0001_0000);
    apb(1'b1, `ACP_OFF_CTRL, 32'h2);
    w1 = $urandom;
    w2 = $urandom;
    apb(1'b1, `ACP_OFF_TXQ, w1);
    fork
      apb(1'b1, `ACP_OFF_TXQ, w2);
      begin
        repeat (12) @(negedge clk);
        chk({31'h0, shared_cpu_irq}, 32'h1);
        txw(w1, 1'b1);
      end
    join
    irqc(1'b0);
    txw(w2, 1'b0);
    rdc(`ACP_OFF_CTRL, 32'h2);
    // Receive clock loss with transmit disabled
    apb(1'b1, `ACP_OFF_CDET, 32'h0014_0014);
    apb(1'b1, `ACP_OFF_CTRL, 32'h1);
    apb(1'b1, `ACP_OFF_ENAB, 32'h2);
    apb(1'b1, `ACP_OFF_PEND, 32'hFFFF_FFFF);
    acp_atm_master_i.rx_byte(1'b0, 8'h00);
    repeat (40) @(posedge clk);
    rdc(`ACP_OFF_PEND, 32'h0000_0006);
    irqc(1'b1);
    rdc(`ACP_OFF_CTRL, 32'h0);
    test_done();
  end
endmodule : acp_port_tb_top
`default_nettype wire

// *** verilog/acp_consts.svh ***
// Offsets, field positions and counts of the cell port error and status block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef ACP_CONSTS_SVH
`define ACP_CONSTS_SVH
// Register byte offsets on the APB port
`define ACP_ADDR_W 8
`define ACP_OFF_CTRL 8'h00
`define ACP_OFF_CDET 8'h04
`define ACP_OFF_PEND 8'h08
`define ACP_OFF_ENAB 8'h0C
`define ACP_OFF_TXQ 8'h10
`define ACP_OFF_RXQ 8'h14
// Control register fields
`define ACP_CTRL_RXEN 0
`define ACP_CTRL_TXEN 1
`define ACP_CTRL_BYTE_ORDER_SEL 2
`define ACP_CTRL_MASK 32'h0000_0007
// Clock detect fields
`define ACP_CDET_TX_LSB 16
`define ACP_CDET_RX_LSB 0
`define ACP_CDET_MASK 32'h00FF_00FF
// Error pending and enable bit positions
`define ACP_TX_PRES 18
`define ACP_TX_FAIL 17
`define ACP_TX_STALL 16
`define ACP_RX_PRES 2
`define ACP_RX_FAIL 1
`define ACP_RX_STALL 0
`define ACP_ERR_MASK 32'h0007_0007
`define ACP_W1C_MASK 32'h0006_0006
// Cell length in 8-bit mode, as index of its last byte
`define ACP_CELL_LAST 6'h34
`define ACP_LANE_LAST 2'h3
`define ACP_CNT_MAX 8'hFF
`endif

// *** verilog/acp_pkg.sv ***
// Types of the cell port error and status block.
// Assumes the constants header sits beside it.
`include "acp_consts.svh"
package acp_pkg;
  // Whole state of the port
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] cdet;
    logic [31:0] pend;
    logic [31:0] enab;
    logic [31:0] prdata;
    logic ready;
    logic slverr;
    logic [2:0] rclk_s;
    logic [1:0] rsoc_s;
    logic [15:0] rdat_s;
    logic [7:0] rcnt;
    logic [5:0] rbytes;
    logic [1:0] rlane;
    logic [31:0] rasm;
    logic [31:0] rword;
    logic rvalid;
    logic [2:0] xclk_s;
    logic [7:0] xcnt;
    logic [5:0] xbytes;
    logic [1:0] xlane;
    logic [31:0] xword;
    logic xvalid;
    logic [7:0] xdat;
    logic xsoc;
    logic xbv;
  } acp_state_t;
endpackage : acp_pkg

// *** verilog/acp_port.sv ***
// Error and status logic of an 8-bit cell port slave, with APB registers.
// Assumes link clocks from the external master, far slower than clk.
// Notes on behaviour
// - Early start marker restarts the receive cell
// - Software cannot force transmit start marker
// - Lost link clock resets that direction
// - Transmit clock failed only while transmit enabled
// - Receive clock failed only while receive enabled
// - Clock present set on any rising edge
// - Interrupt when pending and enable both set
// - Write to full transmit queue stalls
// - Transmit stall clears itself when room
// - Read from empty receive queue stalls; the code stalls only while receive is enabled, else it answers zero at once
// - Receive stall clears when read completes
// - One clears clock bits, stalls ignore writes
// - Enable bits mirror the pending positions
// - Pack link bytes into queue words
// - Little endian by default, swap when selected
// - Zero count disables clock loss detection
// - Everything runs on the peripheral clock
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "acp_consts.svh"
module acp_port
  import acp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ACP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive link
  input wire logic rx_link_clock,
  input wire logic rx_soc,
  input wire logic [7:0] rx_data,
  // Transmit link
  input wire logic tx_link_clock,
  output logic tx_soc,
  output logic [7:0] tx_data,
  output logic tx_byte_valid,
  // Interrupt
  output logic shared_cpu_irq
);

  acp_state_t st_q;
  acp_state_t st_d;

  // Byte order swap of a queue word
  function automatic logic [31:0] acp_swap(input logic [31:0] w);
    acp_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : acp_swap

  // Decode and live conditions
  logic setup;
  logic access;
  logic done;
  logic hit_txq;
  logic hit_rxq;
  logic mapped;
  logic rx_en;
  logic tx_en;
  logic byte_order_sel;
  logic rx_edge;
  logic tx_edge;
  logic tx_stall;
  logic rx_stall;
  logic [31:0] pend_view;
  logic [7:0] rx_limit;
  logic [7:0] tx_limit;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign done = access && pready;
  assign hit_txq = paddr == `ACP_OFF_TXQ;
  assign hit_rxq = paddr == `ACP_OFF_RXQ;
  assign mapped = (paddr == `ACP_OFF_CTRL) || (paddr == `ACP_OFF_CDET) ||
                  (paddr == `ACP_OFF_PEND) || (paddr == `ACP_OFF_ENAB) ||
                  hit_txq || hit_rxq;
  assign rx_en = st_q.ctrl[`ACP_CTRL_RXEN];
  assign tx_en = st_q.ctrl[`ACP_CTRL_TXEN];
  assign byte_order_sel = st_q.ctrl[`ACP_CTRL_BYTE_ORDER_SEL];
  // Edge seen only between second and third stage
  assign rx_edge = st_q.rclk_s[1] && !st_q.rclk_s[2];
  assign tx_edge = st_q.xclk_s[1] && !st_q.xclk_s[2];
  // Stall flags follow the held access
  assign tx_stall = access && !st_q.ready && pwrite && hit_txq;
  assign rx_stall = access && !st_q.ready && !pwrite && hit_rxq;
  assign pend_view = st_q.pend |
                     ({31'h0, rx_stall} << `ACP_RX_STALL) |
                     ({31'h0, tx_stall} << `ACP_TX_STALL);
  assign rx_limit = st_q.cdet[`ACP_CDET_RX_LSB +: 8];
  assign tx_limit = st_q.cdet[`ACP_CDET_TX_LSB +: 8];

  // Outputs
  assign prdata = st_q.prdata;
  assign pready = access && st_q.ready;
  assign pslverr = access && st_q.ready && st_q.slverr;
  assign tx_soc = st_q.xsoc;
  assign tx_data = st_q.xdat;
  assign tx_byte_valid = st_q.xbv;
  assign shared_cpu_irq = |(pend_view & st_q.enab);

  // Next state of the whole block
  always_comb begin
    logic [31:0] rd;
    logic [31:0] asm_v;
    logic [1:0] lane_v;
    logic [5:0] bytes_v;
    logic rx_fail;
    logic tx_fail;
    logic [31:0] hw_set;
    rd = 32'h0;
    asm_v = 32'h0;
    lane_v = 2'h0;
    bytes_v = 6'h0;
    hw_set = 32'h0;
    st_d = st_q;
    // Two-stage synchronisers plus an edge stage
    st_d.rclk_s = {st_q.rclk_s[1:0], rx_link_clock};
    st_d.xclk_s = {st_q.xclk_s[1:0], tx_link_clock};
    st_d.rsoc_s = {st_q.rsoc_s[0], rx_soc};
    st_d.rdat_s = {st_q.rdat_s[7:0], rx_data};

    // Clock loss watchdogs, off when the count is zero
    st_d.rcnt = rx_edge ? 8'h0 :
                (st_q.rcnt == `ACP_CNT_MAX) ? st_q.rcnt : st_q.rcnt + 8'h1;
    st_d.xcnt = tx_edge ? 8'h0 :
                (st_q.xcnt == `ACP_CNT_MAX) ? st_q.xcnt : st_q.xcnt + 8'h1;
    rx_fail = (rx_limit != 8'h0) && (st_d.rcnt == rx_limit);
    tx_fail = (tx_limit != 8'h0) && (st_d.xcnt == tx_limit);
    if (rx_fail) begin
      st_d.rcnt = 8'h0;
    end
    if (tx_fail) begin
      st_d.xcnt = 8'h0;
    end

    // Hardware set events
    hw_set[`ACP_RX_PRES] = rx_edge;
    hw_set[`ACP_TX_PRES] = tx_edge;
    hw_set[`ACP_RX_FAIL] = rx_fail && rx_en;
    hw_set[`ACP_TX_FAIL] = tx_fail && tx_en;

    // Receive packing of link bytes into words
    if (rx_en && rx_edge) begin
      lane_v = st_q.rsoc_s[1] ? 2'h0 : st_q.rlane;
      bytes_v = st_q.rsoc_s[1] ? 6'h0 : st_q.rbytes;
      asm_v = st_q.rsoc_s[1] ? 32'h0 : st_q.rasm;
      asm_v[{lane_v, 3'h0} +: 8] = st_q.rdat_s[15:8];
      if (lane_v == `ACP_LANE_LAST || bytes_v == `ACP_CELL_LAST) begin
        st_d.rword = asm_v;
        st_d.rvalid = 1'b1;
        st_d.rlane = 2'h0;
        st_d.rasm = 32'h0;
      end else begin
        st_d.rlane = lane_v + 2'h1;
        st_d.rasm = asm_v;
      end
      st_d.rbytes = (bytes_v == `ACP_CELL_LAST) ? 6'h0 : bytes_v + 6'h1;
    end

    // Transmit unpacking, start marker only at cell byte zero
    if (tx_en && tx_edge) begin
      st_d.xbv = st_q.xvalid;
      st_d.xsoc = st_q.xvalid && (st_q.xbytes == 6'h0);
      if (st_q.xvalid) begin
        st_d.xdat = st_q.xword[{st_q.xlane, 3'h0} +: 8];
        if (st_q.xlane == `ACP_LANE_LAST || st_q.xbytes == `ACP_CELL_LAST) begin
          st_d.xvalid = 1'b0;
          st_d.xlane = 2'h0;
        end else begin
          st_d.xlane = st_q.xlane + 2'h1;
        end
        st_d.xbytes = (st_q.xbytes == `ACP_CELL_LAST) ? 6'h0 : st_q.xbytes + 6'h1;
      end
    end

    // Read mux for the setup cycle
    unique case (paddr)
      `ACP_OFF_CTRL: rd = st_q.ctrl;
      `ACP_OFF_CDET: rd = st_q.cdet;
      `ACP_OFF_PEND: rd = pend_view;
      `ACP_OFF_ENAB: rd = st_q.enab;
      `ACP_OFF_RXQ: rd = (rx_en && st_q.rvalid) ?
                         (byte_order_sel ? acp_swap(st_q.rword) : st_q.rword) : 32'h0;
      default: rd = 32'h0;
    endcase

    // APB answer: ready unless the queue must hold the access
    if (setup) begin
      st_d.prdata = pwrite ? 32'h0 : rd;
      st_d.slverr = !mapped;
      st_d.ready = !((pwrite && hit_txq && tx_en && st_q.xvalid) ||
                     (!pwrite && hit_rxq && rx_en && !st_q.rvalid));
    end else if (tx_stall && (!st_q.xvalid || !tx_en)) begin
      st_d.ready = 1'b1;
    end else if (rx_stall && (st_q.rvalid || !rx_en)) begin
      st_d.prdata = rd;
      st_d.ready = 1'b1;
    end else if (done) begin
      st_d.ready = 1'b0;
    end

    // Register writes and queue pops at the completing edge
    st_d.pend = st_q.pend;
    if (done && pwrite) begin
      unique case (paddr)
        `ACP_OFF_CTRL: st_d.ctrl = pwdata & `ACP_CTRL_MASK;
        `ACP_OFF_CDET: st_d.cdet = pwdata & `ACP_CDET_MASK;
        `ACP_OFF_PEND: st_d.pend = st_q.pend & ~(pwdata & `ACP_W1C_MASK);
        `ACP_OFF_ENAB: st_d.enab = pwdata & `ACP_ERR_MASK;
        `ACP_OFF_TXQ: begin
          if (tx_en && !st_q.xvalid) begin
            st_d.xword = byte_order_sel ? acp_swap(pwdata) : pwdata;
            st_d.xvalid = 1'b1;
          end
        end
        default: st_d.pend = st_d.pend;
      endcase
    end
    if (done && !pwrite && hit_rxq && !(rx_en && rx_edge && st_d.rword != st_q.rword)) begin
      st_d.rvalid = 1'b0;
    end
    // Set wins over a simultaneous clear
    st_d.pend = (st_d.pend | hw_set) & `ACP_W1C_MASK;

    // Failure or disable returns that direction to reset
    if (hw_set[`ACP_RX_FAIL]) begin
      st_d.ctrl[`ACP_CTRL_RXEN] = 1'b0;
    end
    if (hw_set[`ACP_TX_FAIL]) begin
      st_d.ctrl[`ACP_CTRL_TXEN] = 1'b0;
    end
    if (!st_d.ctrl[`ACP_CTRL_RXEN]) begin
      st_d.rbytes = 6'h0;
      st_d.rlane = 2'h0;
      st_d.rasm = 32'h0;
      st_d.rvalid = 1'b0;
    end
    if (!st_d.ctrl[`ACP_CTRL_TXEN]) begin
      st_d.xbytes = 6'h0;
      st_d.xlane = 2'h0;
      st_d.xvalid = 1'b0;
      st_d.xsoc = 1'b0;
      st_d.xbv = 1'b0;
      st_d.xdat = 8'h0;
    end
  end

  // Single clocked process on the peripheral clock
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  irq_level_a: assert property (shared_cpu_irq == |(pend_view & st_q.enab))
    else $error("irq does not follow pending and enable");
  txfail_en_a: assert property ($rose(st_q.pend[`ACP_TX_FAIL]) |-> $past(tx_en))
    else $error("tx clock failed set while disabled");
  rxfail_en_a: assert property ($rose(st_q.pend[`ACP_RX_FAIL]) |-> $past(rx_en))
    else $error("rx clock failed set while disabled");
  fail_reset_a: assert property ($rose(st_q.pend[`ACP_TX_FAIL]) |-> !tx_en && !st_q.xvalid)
    else $error("tx direction not reset on clock loss");
  pres_set_a: assert property (rx_edge |=> st_q.pend[`ACP_RX_PRES])
    else $error("rx clock present not set");
  tx_stall_a: assert property (tx_stall |-> !pready ##1 (tx_stall || pready || !access))
    else $error("tx stall answered early");
  rx_release_a: assert property (rx_stall && st_q.rvalid |=> pready && !rx_stall)
    else $error("rx stall not released");
  w1c_clear_a: assert property (done && pwrite && paddr == `ACP_OFF_PEND &&
                                pwdata[`ACP_RX_PRES] && !rx_edge |=> !st_q.pend[`ACP_RX_PRES])
    else $error("rx present not cleared by one");
  soc_first_a: assert property ($rose(tx_soc) |-> $past(st_q.xbytes) == 6'h0)
    else $error("tx start marker off cell start");
  runt_a: assert property (rx_en && rx_edge && st_q.rsoc_s[1] && !rst |=>
                           st_q.rbytes == 6'h1 || !rx_en)
    else $error("start marker did not restart cell");

  // Further checks on the receive direction

  // A lost receive clock leaves no word behind
  rxfail_reset_a: assert property ($rose(st_q.pend[`ACP_RX_FAIL]) |-> !rx_en && !st_q.rvalid)
    else $error("rx direction not reset on clock loss");

  // A disabled receiver holds no partial cell
  rx_idle_a: assert property (!rx_en |-> st_q.rbytes == 6'h0 && st_q.rlane == 2'h0)
    else $error("rx state kept while disabled");

  // A stalled read is never answered while the queue is empty and receive is enabled
  rx_stall_hold_a: assert property (rx_stall && !st_q.rvalid && rx_en |-> !pready)
    else $error("rx stall answered early");

  // Zero count keeps the receive failure quiet
  rx_zero_cnt_a: assert property (rx_limit == 8'h0 |=> !$rose(st_q.pend[`ACP_RX_FAIL]))
    else $error("rx failure with detection off");

  // Further checks on the transmit direction

  // Transmit clock present follows every detected edge
  txpres_set_a: assert property (tx_edge |=> st_q.pend[`ACP_TX_PRES])
    else $error("tx clock present not set");

  // A held write leaves the queued word untouched
  tx_keep_a: assert property (tx_stall && st_q.xvalid |=> $stable(st_q.xword))
    else $error("queued tx word overwritten");

  // A disabled transmitter drives no byte
  tx_idle_a: assert property (!tx_en |-> !tx_byte_valid && !tx_soc)
    else $error("tx output while disabled");

  // The start marker only comes with a real byte
  soc_valid_a: assert property (tx_soc |-> tx_byte_valid)
    else $error("tx start marker without byte");

  // Zero count keeps the transmit failure quiet
  tx_zero_cnt_a: assert property (tx_limit == 8'h0 |=> !$rose(st_q.pend[`ACP_TX_FAIL]))
    else $error("tx failure with detection off");

  // Further checks on the registers

  // Stall bits are never stored, they are only a live view
  stall_ro_a: assert property ((st_q.pend & ~`ACP_W1C_MASK) == 32'h0)
    else $error("stall bit stored in pending");

  // Enable register holds only the six source bits
  enab_bits_a: assert property ((st_q.enab & ~`ACP_ERR_MASK) == 32'h0)
    else $error("enable bit outside sources");

  // Writing zero leaves a pending bit set
  w1c_keep_a: assert property (done && pwrite && paddr == `ACP_OFF_PEND &&
                               !pwdata[`ACP_RX_PRES] && st_q.pend[`ACP_RX_PRES] |=>
                               st_q.pend[`ACP_RX_PRES])
    else $error("rx present lost on zero write");

  // No interrupt while nothing enabled is pending
  irq_quiet_a: assert property (!(|(pend_view & st_q.enab)) |-> !shared_cpu_irq)
    else $error("irq without enabled pending bit");

  // Unmapped address answers with an error only when ready
  slverr_a: assert property (pslverr |-> pready && !mapped)
    else $error("slave error off an unmapped access");

  // Runt cell restart and swapped queue read
  runt_c: cover property (rx_en && rx_edge && st_q.rsoc_s[1] && st_q.rbytes != 6'h0);
  swap_c: cover property (done && !pwrite && hit_rxq && byte_order_sel);

  fail_c: cover property ($rose(st_q.pend[`ACP_RX_FAIL]));
  txstall_c: cover property (tx_stall ##[1:100] pready);
  rxpop_c: cover property (rx_stall ##[1:200] pready);

endmodule : acp_port
`default_nettype wire
